// [common/tqd_pkg.sv]
package tqd_pkg;

    // ------------------------------------------------------------------
    // Descriptor layout
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PART_MIDDLE = 2'b00,
        PART_LAST   = 2'b01,
        PART_FIRST  = 2'b10,
        PART_ONLY   = 2'b11
    } tqd_part_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic [5:0] user_tag;
        logic [7:0] frames;
        logic       cnf_repeat;
        logic       cnf_full;
        logic       cnf_inter;
        logic       cnf_end;
        logic [3:0] rclass;
        logic [7:0] frame_control_field;
    } tqd_word0_t;

    typedef struct packed {
        tqd_part_t   part;
        logic [1:0]  reserved;
        logic [25:0] stream_pointer;
        logic [1:0]  byte_bits;
    } tqd_word1_t;

    // ------------------------------------------------------------------
    // Service and confirmation decode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TOK_NONE  = 2'b00,
        TOK_NONR  = 2'b01,
        TOK_RESTR = 2'b10,
        TOK_ANY   = 2'b11
    } tqd_tok_t;

    typedef struct packed {
        tqd_tok_t capture;
        tqd_tok_t issue;
        logic     timer_en;
    } tqd_service_t;

    typedef struct packed {
        logic on_exception;
        logic on_complete;
        logic on_intermediate;
        logic full;
        logic repeat_frame;
    } tqd_confirm_t;

    typedef enum logic [1:0] {
        RING_DATA   = 2'b00,
        RING_CLAIM  = 2'b01,
        RING_BEACON = 2'b10
    } tqd_ring_t;

    localparam logic [3:0] CLS_NONE  = 4'h0;
    localparam logic [3:0] CLS_APR1  = 4'h1;
    localparam logic [3:0] CLS_SYNC  = 4'h4;
    localparam logic [3:0] CLS_IMM   = 4'h5;
    localparam logic [3:0] CLS_IMMN  = 4'h6;
    localparam logic [3:0] CLS_IMMR  = 4'h7;
    localparam logic [3:0] CLS_ASYN  = 4'h8;
    localparam logic [3:0] CLS_RBEG  = 4'h9;
    localparam logic [3:0] CLS_RCNT  = 4'hb;
    localparam logic [3:0] CLS_ASYND = 4'hc;
    localparam logic [3:0] CLS_RBEGD = 4'hd;

    localparam logic [7:0] FC_CLAIM  = 8'hc3;
    localparam logic [7:0] FC_BEACON = 8'hc2;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ATTN  = 8'h04;
    localparam logic [7:0] REG_DESC0 = 8'h08;
    localparam logic [7:0] REG_DESC1 = 8'h0c;
    localparam logic [7:0] REG_STATE = 8'h10;

    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_ABORT  = 1;
    localparam int ATTN_UNSERV = 0;
    localparam int ATTN_BAD    = 1;
    localparam int ATTN_DONE   = 2;

    localparam logic       CTRL_RESET = 1'b0;
    localparam logic [2:0] ATTN_RESET = 3'h0;

endpackage : tqd_pkg

// [verilog/tqd_decode.sv]
// How it works
// - Repeat works only from a first-part descriptor, never from a single-part.
// - Word 0 bits 23..16 hold the frame count; zero is legal.
// - Zero-frame first part: latch fields, drive class, ready low, fetch next.
// - Zero-frame middle part: just fetch the next descriptor.
// - Zero-frame single part: capture token, then pulse final and end request.
// - Zero-frame last part: capture token, pulse final, mark request complete.
// - User tag bits 29..24 come from the first or single-part descriptor.
// - Word 1 bits 27..2 are the stream word address; bits 1..0 unchecked.
// - Part tag 10 first, 00 middle, 01 last, 11 single.
// - Class table: none, priority-one async, async with or without timer.
// - Synchronous class is refused while the beacon latch is set.
// - Restricted classes are refused while any of the three latches is set.
// - Restricted begin waits for a non-restricted token first.
// - Immediate classes only on a non-operational ring, from the FC's state.
// - No confirm bits, or intermediate without end, is a consistency failure.
// - Full alone confirms on exception only.
// - End without full gives transmitter confirm, plus intermediate if set.
// - Full with end gives full confirm, plus intermediate if set.
// - Repeat keeps confirmation behaviour and retransmits the first frame.
// - Class sampled on first or single part; unservable sets the flag.
// - Confirm bits: end 12, intermediate 13, full 14, repeat 15.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps

module tqd_decode (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Descriptor queue
    output logic                       desc_fetch,
    input  wire logic                  desc_valid,
    input  wire tqd_pkg::tqd_word0_t   desc_word0,
    input  wire tqd_pkg::tqd_word1_t   desc_word1,
    // Ring engine
    output logic [3:0]                 request_class_lines,
    output logic                       request_ready_line,
    output logic                       request_final_line,
    output tqd_pkg::tqd_service_t      service,
    input  wire logic                  token_captured,
    input  wire logic                  service_done,
    input  wire logic                  ring_operational,
    input  wire tqd_pkg::tqd_ring_t    ring_state,
    input  wire logic                  beacon_received_latch,
    input  wire logic                  claim_received_latch,
    input  wire logic                  other_station_latch,
    input  wire logic                  nonrestr_token_seen,
    // Request parameters towards the data path
    output logic [25:0]                stream_pointer,
    output logic [7:0]                 frame_count,
    output logic [5:0]                 user_tag,
    output tqd_pkg::tqd_confirm_t      confirm,
    output logic                       request_complete
);
    import tqd_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_FETCH   = 3'b001,
        ST_DECODE  = 3'b010,
        ST_SERVE   = 3'b011,
        ST_CAPTURE = 3'b100,
        ST_FINAL   = 3'b101
    } tqd_state_t;

    tqd_state_t   state;
    tqd_state_t   next_state;
    tqd_word0_t   d0;
    tqd_word1_t   d1;
    logic         ctrl_enable;
    logic [2:0]   attn;
    logic [3:0]   next_class;
    logic         next_ready;
    logic         set_unserv;
    logic         set_bad;
    logic         lead;
    logic         tail;
    logic         cnf_bad;
    logic         ctrl_abort;
    logic         attn_wr;

    assign lead = (d1.part == PART_FIRST) || (d1.part == PART_ONLY);
    assign tail = (d1.part == PART_LAST) || (d1.part == PART_ONLY);
    assign cnf_bad = (!d0.cnf_full && !d0.cnf_inter && !d0.cnf_end)
                   || (d0.cnf_inter && !d0.cnf_end);
    assign ctrl_abort = reg_wr && (reg_addr == REG_CTRL)
                      && reg_wdata[CTRL_ABORT];
    assign attn_wr = reg_wr && (reg_addr == REG_ATTN);

    // ------------------------------------------------------------------
    // Class decode
    // ------------------------------------------------------------------
    // class to token map
    function automatic tqd_service_t svc_of(input logic [3:0] cls);
        tqd_service_t s;
        s = '{capture: TOK_NONE, issue: TOK_NONE, timer_en: 1'b0};
        case (cls)
            CLS_APR1, CLS_ASYN:
                s = '{capture: TOK_NONR, issue: TOK_NONR, timer_en: 1'b1};
            CLS_ASYND:
                s = '{capture: TOK_NONR, issue: TOK_NONR, timer_en: 1'b0};
            CLS_SYNC:
                s = '{capture: TOK_ANY, issue: TOK_ANY, timer_en: 1'b0};
            CLS_IMMN:
                s = '{capture: TOK_NONE, issue: TOK_NONR, timer_en: 1'b0};
            CLS_IMMR:
                s = '{capture: TOK_NONE, issue: TOK_RESTR, timer_en: 1'b0};
            default: begin
                // Restricted group: bit 2 clear keeps the timer on.
                if (cls[3] && (cls[1:0] != 2'b00)) begin
                    s.timer_en = !cls[2];
                    s.capture  = (cls[1:0] == 2'b01) ? TOK_NONR : TOK_RESTR;
                    s.issue    = (cls[1:0] == 2'b10) ? TOK_NONR : TOK_RESTR;
                end
            end
        endcase
        return s;
    endfunction : svc_of

    function automatic logic is_restricted(input logic [3:0] cls);
        return cls[3] && (cls[1:0] != 2'b00);
    endfunction : is_restricted

    function automatic logic class_ok(input logic [3:0] cls,
                                      input logic [7:0] fc);
        tqd_ring_t want;
        logic      ok;
        want = (fc == FC_CLAIM) ? RING_CLAIM
             : (fc == FC_BEACON) ? RING_BEACON : RING_DATA;
        ok = 1'b1;
        if (cls[3:1] == 3'b001) begin
            ok = 1'b0;
        end
        if (cls == CLS_SYNC && beacon_received_latch) begin
            ok = 1'b0;
        end
        if (is_restricted(cls) && (beacon_received_latch
            || claim_received_latch || other_station_latch)) begin
            ok = 1'b0;
        end
        if ((cls >= CLS_IMM) && (cls <= CLS_IMMR)
            && (ring_operational || (ring_state != want))) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : class_ok

    // ------------------------------------------------------------------
    // Request sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_class = request_class_lines;
        set_unserv = 1'b0;
        set_bad    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (ctrl_enable) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (desc_valid) begin
                    next_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (lead && !class_ok(d0.rclass, d0.frame_control_field)) begin
                    set_unserv = 1'b1;
                    next_state = ST_IDLE;
                end else if (lead && cnf_bad) begin
                    set_bad    = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    if (lead) begin
                        next_class = d0.rclass;
                    end
                    if (d0.frames != 8'h00) begin
                        next_state = ST_SERVE;
                    end else if (!tail) begin
                        next_state = ST_FETCH;
                    end else begin
                        next_state = ST_CAPTURE;
                    end
                end
            end
            ST_SERVE: begin
                if (request_ready_line && service_done) begin
                    next_state = tail ? ST_FINAL : ST_FETCH;
                end
            end
            ST_CAPTURE: begin
                if (request_ready_line && token_captured) begin
                    next_state = ST_FINAL;
                end
            end
            ST_FINAL: begin
                next_class = CLS_NONE;
                next_state = ctrl_enable ? ST_FETCH : ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (ctrl_abort) begin
            next_state = ST_IDLE;
        end
        if (next_state == ST_IDLE) begin
            next_class = CLS_NONE;
        end
    end

    always_comb begin
        next_ready = (next_state == ST_SERVE) || (next_state == ST_CAPTURE);
        if (((next_class == CLS_RBEG) || (next_class == CLS_RBEGD))
            && !nonrestr_token_seen) begin
            next_ready = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            request_class_lines <= CLS_NONE;
            request_ready_line  <= 1'b0;
            request_final_line  <= 1'b0;
            request_complete    <= 1'b0;
            desc_fetch          <= 1'b0;
            service             <= '0;
        end else begin
            request_class_lines <= next_class;
            request_ready_line  <= next_ready;
            request_final_line  <= (next_state == ST_FINAL);
            request_complete    <= (next_state == ST_FINAL);
            desc_fetch          <= (next_state == ST_FETCH);
            service             <= svc_of(next_class);
        end
    end

    // ------------------------------------------------------------------
    // Descriptor capture and field latches
    // ------------------------------------------------------------------
    // part tag held with word 1
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            d0 <= '0;
            d1 <= '0;
        end else if (desc_fetch && desc_valid) begin
            d0 <= desc_word0;
            d1 <= desc_word1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stream_pointer <= '0;
            frame_count    <= '0;
            user_tag       <= '0;
            confirm        <= '0;
        end else if (state == ST_DECODE) begin
            stream_pointer <= d1.stream_pointer;
            frame_count    <= d0.frames;
            if (lead) begin
                user_tag <= d0.user_tag;
                confirm.on_exception    <= 1'b1;
                confirm.on_complete     <= d0.cnf_end;
                confirm.on_intermediate <= d0.cnf_inter && d0.cnf_end;
                confirm.full            <= d0.cnf_full;
                confirm.repeat_frame    <= d0.cnf_repeat
                                        && (d1.part == PART_FIRST);
            end
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_enable <= CTRL_RESET;
        end else if (reg_wr && (reg_addr == REG_CTRL)) begin
            ctrl_enable <= reg_wdata[CTRL_ENABLE];
        end
    end

    // Hardware set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            attn <= ATTN_RESET;
        end else begin
            attn <= (attn & ~(attn_wr ? reg_wdata[2:0] : 3'h0))
                  | {request_complete, set_bad, set_unserv};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:  reg_rdata <= {31'h0, ctrl_enable};
                REG_ATTN:  reg_rdata <= {29'h0, attn};
                REG_DESC0: reg_rdata <= d0;
                REG_DESC1: reg_rdata <= d1;
                REG_STATE: reg_rdata <= {21'h0, state, request_class_lines,
                                         request_ready_line,
                                         request_final_line, 2'h0};
                default:   reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_zero_lead;
        state == ST_DECODE && d1.part == PART_FIRST && d0.frames == 8'h00
        && !set_unserv && !set_bad && !ctrl_abort;
    endsequence

    sequence s_captured;
        state == ST_CAPTURE && request_ready_line && token_captured
        && !ctrl_abort;
    endsequence

    a_repeat_first_only: assert property (
        state == ST_DECODE && d1.part == PART_ONLY |=> !confirm.repeat_frame)
        else $error("repeat seen outside first part");

    a_zero_first_fetch: assert property (
        s_zero_lead |=> desc_fetch && !request_ready_line
                        && request_class_lines == $past(d0.rclass))
        else $error("zero first part did not fetch with class driven");

    a_zero_middle_fetch: assert property (
        state == ST_DECODE && d1.part == PART_MIDDLE && d0.frames == 8'h00
        && !ctrl_abort |=> state == ST_FETCH && desc_fetch)
        else $error("zero middle part did not fetch next");

    a_capture_then_final: assert property (
        s_captured |=> request_final_line && request_complete
                       ##1 !request_final_line)
        else $error("final not pulsed after capture");

    a_zero_tail_capture: assert property (
        state == ST_DECODE && tail && d0.frames == 8'h00 && !set_unserv
        && !set_bad && !ctrl_abort |=> state == ST_CAPTURE)
        else $error("zero tail part did not ask for a token");

    a_tag_latched: assert property (
        state == ST_DECODE && lead |=> user_tag == $past(d0.user_tag))
        else $error("user tag not taken from lead part");

    a_sync_beacon: assert property (
        state == ST_DECODE && lead && d0.rclass == CLS_SYNC
        && beacon_received_latch |=> attn[ATTN_UNSERV] && !request_ready_line)
        else $error("sync class served during beacon");

    a_restr_latched: assert property (
        state == ST_DECODE && lead && is_restricted(d0.rclass)
        && other_station_latch |=> attn[ATTN_UNSERV] && state == ST_IDLE)
        else $error("restricted class served with latch set");

    a_rbeg_wait: assert property (
        (request_class_lines == CLS_RBEG) && !$past(nonrestr_token_seen)
        |-> !request_ready_line)
        else $error("restricted begin ready before token seen");

    a_cnf_bad_flag: assert property (
        state == ST_DECODE && lead && cnf_bad && !set_unserv
        |=> attn[ATTN_BAD] ##1 attn[ATTN_BAD] || $past(attn_wr))
        else $error("consistency failure not flagged");

    a_reserved_flag: assert property (
        state == ST_DECODE && lead && d0.rclass[3:1] == 3'b001
        |=> attn[ATTN_UNSERV] && request_class_lines == CLS_NONE)
        else $error("reserved class not refused");

endmodule : tqd_decode

// [testbench/tqd_queue_model.sv]
`timescale 1ns/10ps

module tqd_queue_model (
    // Testbench side
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                push,
    input  wire tqd_pkg::tqd_word0_t push_w0,
    input  wire tqd_pkg::tqd_word1_t push_w1,
    input  wire logic [3:0]          lat,
    // Descriptor queue
    input  wire logic                desc_fetch,
    output logic                     desc_valid,
    output tqd_pkg::tqd_word0_t      desc_word0,
    output tqd_pkg::tqd_word1_t      desc_word1,
    // Ring engine
    input  wire logic                request_ready_line,
    output logic                     token_captured,
    output logic                     service_done
);
    import tqd_pkg::*;
    tqd_word0_t q0[$];
    tqd_word1_t q1[$];
    logic [3:0] cnt;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            desc_valid <= 1'h0;
        end else begin
            if (push) begin
                q0.push_back(push_w0);
                q1.push_back(push_w1);
            end
            if (desc_valid && desc_fetch) begin
                // Released words flip so a stale value is never taken twice.
                void'(q0.pop_front());
                void'(q1.pop_front());
                desc_valid <= 1'h0;
                desc_word0 <= ~desc_word0;
                desc_word1 <= ~desc_word1;
            end else if (!desc_valid && q0.size() > 0) begin
                desc_valid <= 1'h1;
                desc_word0 <= q0[0];
                desc_word1 <= q1[0];
            end
        end
    end
    // The answer comes lat+1 cycles after ready rises, as a one-cycle pulse.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            token_captured <= 1'h0;
            service_done <= 1'h0;
        end else if (request_ready_line && !token_captured && cnt == lat) begin
            cnt <= 4'h0;
            token_captured <= 1'h1;
            service_done <= 1'h1;
        end else begin
            cnt <= request_ready_line ? cnt + 4'h1 : 4'h0;
            token_captured <= 1'h0;
            service_done <= 1'h0;
        end
    end
endmodule : tqd_queue_model

// [testbench/tqd_decode_tb_top.sv]
`timescale 1ns/10ps

module tqd_decode_tb_top;
    import tqd_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, push = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic desc_fetch, desc_valid, token_captured, service_done;
    tqd_word0_t desc_word0, push_w0 = '0;
    tqd_word1_t desc_word1, push_w1 = '0;
    logic [3:0] request_class_lines, lat = 4'h0;
    logic request_ready_line, request_final_line, request_complete;
    tqd_service_t service;
    tqd_confirm_t confirm;
    logic ring_operational = 1'h1, nonrestr_token_seen = 1'h1;
    tqd_ring_t ring_state = RING_DATA;
    logic beacon_received_latch = 1'h0, claim_received_latch = 1'h0;
    logic other_station_latch = 1'h0;
    logic [25:0] stream_pointer;
    logic [7:0] frame_count;
    logic [5:0] user_tag;
    int n_mismatch = 0, checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    tqd_decode dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .desc_fetch, .desc_valid, .desc_word0, .desc_word1,
        .request_class_lines, .request_ready_line, .request_final_line,
        .service, .token_captured, .service_done, .ring_operational,
        .ring_state, .beacon_received_latch, .claim_received_latch,
        .other_station_latch, .nonrestr_token_seen, .stream_pointer,
        .frame_count, .user_tag, .confirm, .request_complete);
    tqd_queue_model far_u (.clk, .rstn, .push, .push_w0, .push_w1, .lat,
        .desc_fetch, .desc_valid, .desc_word0, .desc_word1,
        .request_ready_line, .token_captured, .service_done);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // Pointer low bits are always sent as 00.
    function automatic tqd_word1_t w1f(input tqd_part_t p, input logic [25:0] a);
        return {p, 2'h0, a, 2'h0};
    endfunction : w1f
    task automatic put(input logic [5:0] t, input logic [7:0] f, input logic [3:0] c,
        input logic [3:0] k, input logic [7:0] fc, input tqd_word1_t w1);
        @(posedge clk);
        push <= 1'h1;
        push_w0 <= {2'h0, t, f, c, k, fc};
        push_w1 <= w1;
        @(posedge clk);
        push <= 1'h0;
    endtask : put
    task automatic wfin(input string nm);
        int i;
        for (i = 0; i < 300 && request_final_line !== 1'h1; i++) @(posedge clk) #1;
        chk(nm, 32'h1, {31'h0, request_complete});
    endtask : wfin
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_only;
        put(6'h2a, 8'h00, 4'h1, CLS_ASYN, 8'h50, w1f(PART_ONLY, 26'h123456));
        wfin("only_done");
        chk("only_cls", 32'h8, request_class_lines);
        chk("only_srv", 32'h0b, service);
        chk("only_tag", 32'h2a, user_tag);
        chk("only_ptr", 32'h123456, stream_pointer);
        chk("only_cnf", 32'h18, confirm);
        @(posedge clk) #1;
        chk("idle_cls", 32'h0, request_class_lines);
    endtask : t_only
    task automatic t_chain;
        lat <= 4'h5;
        put(6'h11, 8'h00, 4'hd, CLS_SYNC, 8'h50, w1f(PART_FIRST, 26'h10));
        put(6'h3f, 8'h00, 4'h0, CLS_ASYN, 8'h50, w1f(PART_MIDDLE, 26'h20));
        repeat (6) @(posedge clk);
        chk("first_rdy", 32'h0, request_ready_line);
        chk("first_cls", 32'h4, request_class_lines);
        put(6'h3f, 8'h00, 4'h0, CLS_ASYN, 8'h50, w1f(PART_LAST, 26'h30));
        wfin("last_done");
        chk("last_cls", 32'h4, request_class_lines);
        chk("last_tag", 32'h11, user_tag);
        chk("last_cnf", 32'h1b, confirm);
    endtask : t_chain
    task automatic t_nonzero;
        lat <= 4'h2;
        put(6'h01, 8'h03, 4'hb, CLS_APR1, 8'h50, w1f(PART_ONLY, 26'h40));
        wfin("nz_done");
        chk("nz_cnt", 32'h3, frame_count);
        chk("nz_srv", 32'h0b, service);
        chk("nz_cnf", 32'h1c, confirm);
        put(6'h01, 8'h00, 4'h4, CLS_ASYND, 8'h50, w1f(PART_ONLY, 26'h44));
        wfin("fx_done");
        chk("fx_srv", 32'h0a, service);
        chk("fx_cnf", 32'h12, confirm);
    endtask : t_nonzero
    task automatic t_restr;
        nonrestr_token_seen <= 1'h0;
        put(6'h05, 8'h00, 4'h1, CLS_RBEG, 8'h50, w1f(PART_ONLY, 26'h50));
        repeat (10) @(posedge clk);
        chk("rb_hold", 32'h0, request_ready_line);
        rd(REG_STATE);
        chk("rb_state", 32'h490, rd_val);
        nonrestr_token_seen <= 1'h1;
        wfin("rb_done");
        chk("rb_srv", 32'h0d, service);
    endtask : t_restr
    task automatic t_refuse;
        logic [10:0] tbl[7] = '{{4'h4, 3'h4, 4'h1}, {4'h2, 3'h0, 4'h1},
            {4'hb, 3'h2, 4'h1}, {4'hf, 3'h1, 4'h1}, {4'h8, 3'h0, 4'h0},
            {4'h8, 3'h0, 4'h2}, {4'h5, 3'h0, 4'h1}};
        for (int i = 0; i < 7; i++) begin
            wr(REG_ATTN, 32'h7);
            {beacon_received_latch, claim_received_latch,
                other_station_latch} <= tbl[i][6:4];
            put(6'h00, 8'h00, tbl[i][3:0], tbl[i][10:7], 8'h50,
                w1f(PART_ONLY, 26'h60));
            repeat (8) @(posedge clk);
            rd(REG_ATTN);
            chk("refuse", (i > 3 && i < 6) ? 32'h2 : 32'h1, rd_val);
        end
        {beacon_received_latch, claim_received_latch, other_station_latch} <= 3'h0;
    endtask : t_refuse
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        rd(REG_CTRL);
        chk("ctrl_rst", 32'h0, rd_val);
        rd(8'h3c);
        chk("unmapped", 32'h0, rd_val);
        wr(REG_CTRL, 32'h1);
        t_only();
        rd(REG_DESC1);
        chk("only_w1", w1f(PART_ONLY, 26'h123456), rd_val);
        t_chain();
        t_nonzero();
        t_restr();
        t_refuse();
        ring_operational <= 1'h0;
        ring_state <= RING_CLAIM;
        put(6'h00, 8'h00, 4'h1, CLS_IMMN, FC_CLAIM, w1f(PART_ONLY, 26'h70));
        wfin("imm_done");
        chk("imm_srv", 32'h02, service);
        final_report();
    end
endmodule : tqd_decode_tb_top
